// ---- include/tic_pkg.sv ----
// Package: addresses, fields, reset values and types of the timer input capture unit
package tic_pkg;

  // Register addresses on the 8-bit I/O bus
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h81;
  localparam logic [7:0] ADDR_CAP_LO = 8'h86;
  localparam logic [7:0] ADDR_CAP_HI = 8'h87;
  localparam logic [7:0] ADDR_FLAGS  = 8'h36;
  localparam logic [7:0] ADDR_MASK   = 8'h6F;

  // Field positions
  localparam int CTRLB_FILT_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam int CTRLB_RSVD_BIT = 5;
  localparam int CTRLB_WGM_LSB  = 3;
  localparam int CTRLB_CS_LSB   = 0;
  localparam int CTRLA_WGM_LSB  = 0;
  localparam int FLAG_BIT       = 5;
  localparam int MASK_BIT       = 5;

  // Writable bits of timer_control_b
  localparam logic [7:0] CTRLB_WR_MASK = 8'hDF;

  // Reset values
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [1:0]  WGM_LO_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // Prescaler and filter sizes
  localparam int PRESC_WIDTH    = 10;
  localparam int DIV8_LOG       = 3;
  localparam int DIV64_LOG      = 6;
  localparam int DIV256_LOG     = 8;
  localparam int DIV1024_LOG    = 10;
  localparam int FILTER_SAMPLES = 4;

  // Clock source codes
  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tic_cs_e;

endpackage

// ---- src/tic_prescaler.sv ----
// Prescaler and clock source select producing the counter tick
`timescale 1ns/1ps
module tic_prescaler #(
  parameter int WIDTH = tic_pkg::PRESC_WIDTH
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic            clkEn,
  // Control
  input  wire tic_pkg::tic_cs_e clockSourceSelect,
  input  wire logic            externalCountPin,
  // Tick
  output logic                 countTick
);
  import tic_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] div;
    logic [1:0]       extSync;
    logic             extPrev;
  } tic_presc_s;

  tic_presc_s q;
  tic_presc_s d;

  always_comb begin
    d         = q;
    d.div     = q.div + 1'b1;
    d.extSync = {q.extSync[0], externalCountPin};
    d.extPrev = q.extSync[1];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  always_comb begin
    unique case (clockSourceSelect)
      CS_STOP:     countTick = 1'b0;                          // [R11]
      CS_DIV1:     countTick = 1'b1;                          // [R12]
      CS_DIV8:     countTick = &q.div[DIV8_LOG-1:0];          // [R12]
      CS_DIV64:    countTick = &q.div[DIV64_LOG-1:0];         // [R12]
      CS_DIV256:   countTick = &q.div[DIV256_LOG-1:0];        // [R12]
      CS_DIV1024:  countTick = &q.div[DIV1024_LOG-1:0];       // [R12]
      CS_EXT_FALL: countTick = q.extPrev & ~q.extSync[1];     // [R13]
      CS_EXT_RISE: countTick = ~q.extPrev & q.extSync[1];     // [R13]
    endcase
  end

endmodule // tic_prescaler

// ---- src/tic_noise_filter.sv ----
// Input synchroniser with optional four-sample noise filter
`timescale 1ns/1ps
module tic_noise_filter #(
  parameter int SAMPLES = tic_pkg::FILTER_SAMPLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  // Input and control
  input  wire logic rawIn,
  input  wire logic filterEn,
  // Filtered level
  output logic      level
);
  import tic_pkg::*;

  typedef struct packed {
    logic [1:0]         sync;
    logic [SAMPLES-1:0] hist;
    logic               out;
  } tic_filt_s;

  tic_filt_s q;
  tic_filt_s d;

  always_comb begin
    d      = q;
    d.sync = {q.sync[0], rawIn};                              // [R16]
    d.hist = {q.hist[SAMPLES-2:0], q.sync[1]};
    if (&q.hist) begin
      d.out = 1'b1;                                           // [R7]
    end else if (~|q.hist) begin
      d.out = 1'b0;                                           // [R7]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign level = filterEn ? q.out : q.sync[1];                // [R7]

  property p_filter_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    (clkEn && !(&q.hist) && (|q.hist)) |=> $stable(q.out);
  endproperty
  a_filter_hold: assert property (p_filter_hold)              // [R7]
    else $error("Filter output changed without four equal samples");

endmodule // tic_noise_filter

// ---- src/tic_input_capture.sv ----
// Input capture unit of a 16-bit timer with control register B and byte access
//
// What this block does
// [R1] A selected edge on the capture input copies the whole 16-bit counter into the capture register.
// [R2] The capture flag rises in the same clock in which the counter is stored.
// [R3] With the interrupt enable set the flag requests an interrupt and clears when serviced.
// [R4] Writing one to the flag bit clears the flag and writing zero leaves it alone.
// [R5] Reading the low byte loads the high byte into the shared latch, read later at the high address.
// [R6] The capture register is writable only while the waveform mode uses it as TOP.
// [R7] With the noise filter on, the level changes only after four equal samples.
// [R8] The edge select bit picks a falling edge at zero and a rising edge at one.
// [R9] While the capture register is TOP the capture input is cut off and no captures happen.
// [R10] Bit 5 of control register B reads as zero and software writes it as zero.
// [R11] Clock select zero gives the counter no clock, so it stops.
// [R12] Codes 001 to 101 count at the I/O clock divided by 1, 8, 64, 256 and 1024.
// [R13] Code 110 counts falling and code 111 rising edges of the external count pin.
// [R14] Bits 4 and 3 of control register B are the upper two waveform mode bits.
// [R15] A 16-bit write puts the high byte in the latch first; the low write moves both at once.
// [R16] The capture input is synchronised and edges found by comparing with the previous sample.
// [R17] A select input from the comparator block picks the pin or the comparator as source.
`timescale 1ns/1ps
module tic_input_capture (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // I/O bus
  input  wire logic [7:0]  ioAddr,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [7:0]  ioWdata,
  output logic      [7:0]  ioRdata,
  // Capture sources
  input  wire logic        capturePin,
  input  wire logic        comparatorOutput,
  input  wire logic        comparatorSelect,
  // Count clock pin
  input  wire logic        externalCountPin,
  // Interrupt handshake
  input  wire logic        irqAck,
  output logic             captureIrq,
  // Timer value
  output logic      [15:0] counterValue
);
  import tic_pkg::*;

  typedef struct packed {
    logic [1:0]  wgmLo;
    logic [7:0]  ctrlB;
    logic [15:0] capture;
    logic [7:0]  temp;
    logic        flag;
    logic        irqEn;
    logic [15:0] counter;
    logic        prevLevel;
    logic [7:0]  rdata;
  } tic_state_s;

  tic_state_s q;
  tic_state_s d;

  logic       rawSource;
  logic       level;
  logic       countTick;
  logic [3:0] wgm;
  logic       icrTop;
  logic       rising;
  logic       falling;
  logic       capEvent;
  logic       wrCtrlA;
  logic       wrCtrlB;
  logic       wrCapLo;
  logic       wrCapHi;
  logic       wrFlags;
  logic       wrMask;
  logic       rdCapLo;
  tic_cs_e    csField;

  // Source select and conditioning
  assign rawSource = comparatorSelect ? comparatorOutput : capturePin; // [R17]

  tic_noise_filter #(
    .SAMPLES (FILTER_SAMPLES)
  ) u_filter (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .rawIn    (rawSource),
    .filterEn (q.ctrlB[CTRLB_FILT_BIT]),
    .level    (level)
  );

  assign csField = tic_cs_e'(q.ctrlB[CTRLB_CS_LSB +: 3]);

  tic_prescaler #(
    .WIDTH (PRESC_WIDTH)
  ) u_presc (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .clkEn             (clkEn),
    .clockSourceSelect (csField),
    .externalCountPin  (externalCountPin),
    .countTick         (countTick)
  );

  // Waveform mode and capture trigger
  assign wgm = {q.ctrlB[CTRLB_WGM_LSB +: 2], q.wgmLo};        // [R14]
  assign icrTop = wgm[3] & ~wgm[0];

  assign rising  = level & ~q.prevLevel;                      // [R16]
  assign falling = ~level & q.prevLevel;                      // [R16]
  assign capEvent = ~icrTop &                                 // [R9]
                    (q.ctrlB[CTRLB_EDGE_BIT] ? rising : falling); // [R8]

  // Bus decode
  assign wrCtrlA = ioWrite && (ioAddr == ADDR_CTRL_A);
  assign wrCtrlB = ioWrite && (ioAddr == ADDR_CTRL_B);
  assign wrCapLo = ioWrite && (ioAddr == ADDR_CAP_LO);
  assign wrCapHi = ioWrite && (ioAddr == ADDR_CAP_HI);
  assign wrFlags = ioWrite && (ioAddr == ADDR_FLAGS);
  assign wrMask  = ioWrite && (ioAddr == ADDR_MASK);
  assign rdCapLo = ioRead && (ioAddr == ADDR_CAP_LO);

  always_comb begin
    d = q;
    d.prevLevel = level;                                      // [R16]

    // Counter
    if (countTick) begin                                      // [R11]
      if (icrTop && (q.counter == q.capture)) begin
        d.counter = WORD_RESET;
      end else begin
        d.counter = q.counter + 16'h0001;
      end
    end

    // Control registers
    if (wrCtrlA) begin
      d.wgmLo = ioWdata[CTRLA_WGM_LSB +: 2];
    end
    if (wrCtrlB) begin
      d.ctrlB = ioWdata & CTRLB_WR_MASK;                      // [R10]
    end
    if (wrMask) begin
      d.irqEn = ioWdata[MASK_BIT];
    end

    // Shared high-byte latch
    if (wrCapHi) begin
      d.temp = ioWdata;                                       // [R15]
    end
    if (rdCapLo) begin
      d.temp = q.capture[15:8];                               // [R5]
    end

    // Capture register
    if (wrCapLo && icrTop) begin                              // [R6]
      d.capture = {q.temp, ioWdata};                          // [R15]
    end
    if (capEvent) begin
      d.capture = q.counter;                                  // [R1]
    end

    // Flag: set wins over any clear
    if ((wrFlags && ioWdata[FLAG_BIT]) || irqAck) begin
      d.flag = 1'b0;                                          // [R3] [R4]
    end
    if (capEvent) begin
      d.flag = 1'b1;                                          // [R2]
    end

    // Read data
    if (ioRead) begin
      unique case (ioAddr)
        ADDR_CTRL_A: d.rdata = {6'h00, q.wgmLo};
        ADDR_CTRL_B: d.rdata = q.ctrlB;                       // [R10]
        ADDR_CAP_LO: d.rdata = q.capture[7:0];                // [R5]
        ADDR_CAP_HI: d.rdata = q.temp;                        // [R5]
        ADDR_FLAGS:  d.rdata = {2'h0, q.flag, 5'h00};
        ADDR_MASK:   d.rdata = {2'h0, q.irqEn, 5'h00};
        default:     d.rdata = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q.wgmLo     <= WGM_LO_RESET;
      q.ctrlB     <= BYTE_RESET;
      q.capture   <= WORD_RESET;
      q.temp      <= BYTE_RESET;
      q.flag      <= 1'b0;
      q.irqEn     <= 1'b0;
      q.counter   <= WORD_RESET;
      q.prevLevel <= 1'b0;
      q.rdata     <= BYTE_RESET;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign ioRdata      = q.rdata;
  assign counterValue = q.counter;
  assign captureIrq   = q.flag & q.irqEn;                     // [R3]

  // Checks
  logic capStrobe;
  assign capStrobe = capEvent & clkEn;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property p_capture_copy;
    capStrobe |=> (q.capture == $past(q.counter));
  endproperty
  a_capture_copy: assert property (p_capture_copy) // [R1]
    else $error("Capture register did not take the counter value");

  property p_flag_same;
    capStrobe |=> (q.flag && q.capture == $past(q.counter));
  endproperty
  a_flag_same: assert property (p_flag_same) // [R2]
    else $error("Flag not set together with the capture");

  property p_irq_service;
    (clkEn && irqAck && !capEvent) |=> (!q.flag && !captureIrq);
  endproperty
  a_irq_service: assert property (p_irq_service) // [R3]
    else $error("Flag survived interrupt service");

  property p_flag_write;
    (clkEn && wrFlags && !ioWdata[FLAG_BIT] && !irqAck && !capEvent)
      |=> $stable(q.flag);
  endproperty
  a_flag_write: assert property (p_flag_write) // [R4]
    else $error("Writing zero changed the flag");

  property p_temp_load;
    (clkEn && rdCapLo) ##1 (clkEn && ioRead && ioAddr == ADDR_CAP_HI)
      |=> (ioRdata == $past(q.capture[15:8], 2));
  endproperty
  a_temp_load: assert property (p_temp_load) // [R5]
    else $error("High byte read did not return latched value");

  property p_write_block;
    (clkEn && wrCapLo && !icrTop && !capEvent) |=> $stable(q.capture);
  endproperty
  a_write_block: assert property (p_write_block) // [R6]
    else $error("Capture register written outside TOP mode");

  property p_no_capture_top;
    (clkEn && icrTop && !wrCapLo) |=> ($stable(q.capture) && !$rose(q.flag));
  endproperty
  a_no_capture_top: assert property (p_no_capture_top) // [R9]
    else $error("Capture while register is TOP");

  property p_edge_sel;
    (clkEn && !icrTop && level != q.prevLevel && level == q.ctrlB[CTRLB_EDGE_BIT]) |=> q.flag;
  endproperty
  a_edge_sel: assert property (p_edge_sel) // [R8]
    else $error("Capture on the wrong edge");

  property p_rsvd_zero;
    (clkEn && ioRead && ioAddr == ADDR_CTRL_B) |=> !ioRdata[CTRLB_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [R10]
    else $error("Reserved bit read as one");

  property p_stopped;
    (csField == CS_STOP) |=> $stable(q.counter);
  endproperty
  a_stopped: assert property (p_stopped) // [R11]
    else $error("Counter moved with no clock source");

  property p_wr16;
    (clkEn && wrCapLo && icrTop) |=> (q.capture == {$past(q.temp), $past(ioWdata)});
  endproperty
  a_wr16: assert property (p_wr16) // [R15]
    else $error("16-bit write did not merge latch and low byte");

  c_capture:  cover property (capStrobe);
  c_filtered: cover property (capStrobe && q.ctrlB[CTRLB_FILT_BIT]);
  c_read16:   cover property ((clkEn && rdCapLo) ##1 (clkEn && ioRead));
  c_top_wr:   cover property (clkEn && wrCapLo && icrTop);

endmodule // tic_input_capture

// ---- test/tic_event_model.sv ----
// Behavioural source of capture events and external count clock edges
`timescale 1ns/1ps
module tic_event_model (
  // Clock
  input  wire logic sys_clk,
  // Driven lines, idle low
  output logic      capturePin,
  output logic      comparatorOutput,
  output logic      externalCountPin
);
  initial begin
    capturePin       = 1'b0;
    comparatorOutput = 1'b0;
    externalCountPin = 1'b0;
  end

  // Sets one line just after an edge: 0 pin, 1 comparator, 2 count pin
  task automatic drive(input int sel, input logic v);
    @(posedge sys_clk);
    case (sel)
      0: capturePin <= v;
      1: comparatorOutput <= v;
      default: externalCountPin <= v;
    endcase
  endtask

  // High pulse lasting len cycles
  task automatic pulse(input int sel, input int len);
    drive(sel, 1'b1);
    repeat (len - 1) @(posedge sys_clk);
    drive(sel, 1'b0);
  endtask
endmodule // tic_event_model

// ---- test/tic_input_capture_tb.sv ----
// Testbench of the timer input capture unit
`timescale 1ns/1ps
module tic_input_capture_tb;
  import tic_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst;
  logic        clkEn;
  logic [7:0]  ioAddr;
  logic        ioWrite;
  logic        ioRead;
  logic [7:0]  ioWdata;
  logic [7:0]  ioRdata;
  logic        capturePin;
  logic        comparatorOutput;
  logic        comparatorSelect;
  logic        externalCountPin;
  logic        irqAck;
  logic        captureIrq;
  logic [15:0] counterValue;
  logic [15:0] c0;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          divs [5] = '{1, 8, 64, 256, 1024};

  always #10 sys_clk = ~sys_clk;

  tic_input_capture dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata),
    .ioRdata(ioRdata), .capturePin(capturePin), .comparatorOutput(comparatorOutput),
    .comparatorSelect(comparatorSelect), .externalCountPin(externalCountPin),
    .irqAck(irqAck), .captureIrq(captureIrq), .counterValue(counterValue));

  tic_event_model src (.sys_clk(sys_clk), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput), .externalCountPin(externalCountPin));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus write: strobe held one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ioAddr  <= a;
    ioWdata <= d;
    ioWrite <= 1'b1;
    @(posedge sys_clk);
    ioWrite <= 1'b0;
  endtask

  // Bus read, data compared under a mask the cycle after
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                      input string name);
    @(posedge sys_clk);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge sys_clk);
    ioRead <= 1'b0;
    #1;
    chk(name, {8'h00, ioRdata & m}, {8'h00, e & m});
  endtask

  // 16-bit read: low byte then high byte on consecutive edges
  task automatic rchk16(input logic [15:0] e, input string name);
    logic [7:0] lo;
    @(posedge sys_clk);
    ioAddr <= ADDR_CAP_LO;
    ioRead <= 1'b1;
    @(posedge sys_clk);
    ioAddr <= ADDR_CAP_HI;
    #1;
    lo = ioRdata;
    @(posedge sys_clk);
    ioRead <= 1'b0;
    #1;
    chk(name, {ioRdata, lo}, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic extPulses(input int n);
    for (int i = 0; i < n; i++) begin
      src.pulse(2, 4);
      repeat (4) @(posedge sys_clk);
    end
    wt(6);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    sys_rst = 1'b1; clkEn = 1'b1; ioAddr = 8'h00; ioWrite = 1'b0; ioRead = 1'b0;
    ioWdata = 8'h00; comparatorSelect = 1'b0; irqAck = 1'b0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(ADDR_CTRL_B, 8'h00, 8'hFF, "ctrlBReset");
    rchk(ADDR_CAP_LO, 8'h00, 8'hFF, "capReset");
    wr(ADDR_CTRL_B, 8'hFF);
    rchk(ADDR_CTRL_B, 8'hDF, 8'hFF, "ctrlBBits");
    wr(ADDR_CTRL_B, 8'h47);
    extPulses(3);
    chk("extRise", counterValue, 16'h0003);
    wr(ADDR_CTRL_B, 8'h46);
    extPulses(257);
    chk("extFall", counterValue, 16'h0104);
    wr(ADDR_CTRL_B, 8'h40);
    wt(20);
    chk("stopped", counterValue, 16'h0104);
    src.pulse(0, 2);
    wt(8);
    rchk(ADDR_FLAGS, 8'h20, 8'h20, "flagSet");
    rchk(ADDR_CAP_LO, 8'h04, 8'hFF, "capLo");
    rchk(ADDR_CAP_HI, 8'h01, 8'hFF, "capHi");
    wr(ADDR_FLAGS, 8'h00);
    rchk(ADDR_FLAGS, 8'h20, 8'h20, "flagKeep");
    wr(ADDR_FLAGS, 8'h20);
    rchk(ADDR_FLAGS, 8'h00, 8'h20, "flagClr");
    wr(ADDR_CTRL_B, 8'h00);
    src.drive(0, 1'b1);
    wt(8);
    rchk(ADDR_FLAGS, 8'h00, 8'h20, "riseIgnored");
    src.drive(0, 1'b0);
    wt(8);
    rchk(ADDR_FLAGS, 8'h20, 8'h20, "fallTaken");
    chk("irqOff", captureIrq, 16'h0000);
    wr(ADDR_MASK, 8'h20);
    wt(1);
    chk("irqOn", captureIrq, 16'h0001);
    @(posedge sys_clk);
    irqAck <= 1'b1;
    @(posedge sys_clk);
    irqAck <= 1'b0;
    wt(2);
    chk("irqAck", captureIrq, 16'h0000);
    wr(ADDR_CTRL_B, 8'hC0);
    src.pulse(0, 3);
    wt(12);
    rchk(ADDR_FLAGS, 8'h00, 8'h20, "shortSpike");
    src.pulse(0, 6);
    wt(12);
    rchk(ADDR_FLAGS, 8'h20, 8'h20, "longPulse");
    wr(ADDR_FLAGS, 8'h20);
    wr(ADDR_CTRL_B, 8'h40);
    comparatorSelect <= 1'b1;
    src.pulse(0, 2);
    wt(8);
    rchk(ADDR_FLAGS, 8'h00, 8'h20, "pinDeselected");
    src.pulse(1, 2);
    wt(8);
    rchk(ADDR_FLAGS, 8'h20, 8'h20, "comparator");
    wr(ADDR_FLAGS, 8'h20);
    comparatorSelect <= 1'b0;
    wr(ADDR_CAP_HI, 8'hAB);
    wr(ADDR_CAP_LO, 8'hCD);
    rchk(ADDR_CAP_LO, 8'h04, 8'hFF, "capLoLocked");
    rchk(ADDR_CAP_HI, 8'h01, 8'hFF, "capHiLocked");
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h58);
    wr(ADDR_CAP_HI, 8'h12);
    wr(ADDR_CAP_LO, 8'h34);
    rchk(ADDR_CAP_LO, 8'h34, 8'hFF, "topLo");
    rchk(ADDR_CAP_HI, 8'h12, 8'hFF, "topHi");
    rchk16(16'h1234, "top16");
    src.pulse(0, 2);
    wt(8);
    rchk(ADDR_FLAGS, 8'h00, 8'h20, "topNoCapture");
    rchk(ADDR_CAP_LO, 8'h34, 8'hFF, "topKept");
    rchk(8'h90, 8'h00, 8'hFF, "unmapped");
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CTRL_B, 8'(k + 1));
      wt(4);
      c0 = counterValue;
      wt(3 * divs[k]);
      chk("rate", counterValue - c0, 16'h0003);
    end
    wr(ADDR_CTRL_B, 8'h01);
    clkEn <= 1'b0;
    wt(2);
    c0 = counterValue;
    wt(10);
    chk("frozen", counterValue, c0);
    clkEn <= 1'b1;
    wt(4);
    chk("resumed", counterValue - c0, 16'h0004);
    wrap_up();
  end
endmodule // tic_input_capture_tb
